// ===== design/pzi_defs.vh
/*
 * Constants for the port-zero MII input-side pin block.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef PZI_DEFS_VH
`define PZI_DEFS_VH

// Port modes
`define PZI_MODE_MII_MAC 2'h0
`define PZI_MODE_MII_PHY 2'h1
`define PZI_MODE_RMII_PHY 2'h2

// Reference clock divider for MII PHY mode: 100 MHz / (2*5) = 10 MHz link
`define PZI_REFCLK_HALF 4'h5
`define PZI_REFCLK_W 4

// Drive strength codes on the clock pad
`define PZI_DRIVE_12MA 1'h0
`define PZI_DRIVE_16MA 1'h1

// Nibble and dibit widths
`define PZI_MII_BITS 4
`define PZI_RMII_BITS 2

`endif

// ===== design/pzi_sync2.v
/*
 * Two-flop synchroniser, one per bit by generate.
 * Assumes inputs arrive asynchronously to clk_sys_i.
 */
`timescale 1ns/1ns
`default_nettype none
module pzi_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Data
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta;
      reg stable;
      always @(posedge clk_sys_i) begin
        if (reset_i) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= async_i[g];
          stable <= meta;
        end
      end
      assign sync_o[g] = stable;
    end
  endgenerate
endmodule // pzi_sync2
`default_nettype wire

// ===== design/pzi_port_zero_in.v
/*
 * Input side of port zero's media-independent interface: valid, error and
 * reference clock pins, with their role set by the port mode.
 * Assumes mode, isolate and clock-strength bits come from same-clock logic;
 * all pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pzi_defs.vh"
module pzi_port_zero_in (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Configuration from same-clock logic
  input wire [1:0] port_mode_i,
  input wire virtual_phy_isolate_i,
  input wire clk_strength_i,
  input wire turbo_200_i,
  // Pins
  input wire port_zero_in_valid_i,
  input wire port_zero_in_error_i,
  input wire [3:0] port_zero_in_bits_i,
  input wire port_zero_in_refclk_i,
  output reg port_zero_in_refclk_o,
  output reg port_zero_in_refclk_oe_n_o,
  output reg port_zero_in_drive_16ma_o,
  output reg port_zero_in_input_en_o,
  output reg port_zero_in_pulldown_en_o,
  // Toward port receive logic
  output reg rx_strobe_o,
  output reg rx_valid_o,
  output reg [3:0] rx_bits_o,
  output reg rx_width_rmii_o,
  output reg rx_error_mark_o,
  output reg rx_abort_o
);

////////////////////////////////////////////////////////////////////////
  wire mode_mac = (port_mode_i == `PZI_MODE_MII_MAC);
  wire mode_phy = (port_mode_i == `PZI_MODE_MII_PHY);
  wire mode_rmii = (port_mode_i == `PZI_MODE_RMII_PHY);
  wire iso_pins = virtual_phy_isolate_i & (mode_phy | mode_rmii);

  // Every pin passes two flops before any use
  wire [6:0] pin_sync;
  pzi_sync2 #(
    .WIDTH(7)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i({port_zero_in_refclk_i, port_zero_in_error_i, port_zero_in_valid_i, port_zero_in_bits_i}),
    .sync_o(pin_sync)
  );

  wire [3:0] s_bits = pin_sync[3:0];
  wire s_valid = pin_sync[4];
  wire s_error = pin_sync[5];
  wire s_refclk = pin_sync[6];

////////////////////////////////////////////////////////////////////////
  // Local refclk generator for MII PHY mode
  reg [`PZI_REFCLK_W-1:0] div_cnt;
  reg gen_clk;
  reg gen_rise;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      div_cnt <= {`PZI_REFCLK_W{1'b0}};
      gen_clk <= 1'b0;
      gen_rise <= 1'b0;
    end else begin
      gen_rise <= 1'b0;
      if (div_cnt == `PZI_REFCLK_HALF - 4'h1) begin
        div_cnt <= {`PZI_REFCLK_W{1'b0}};
        gen_clk <= ~gen_clk;
        gen_rise <= ~gen_clk;
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  // RMII PHY: no refclk on this pin; sample at the generated rate
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      port_zero_in_refclk_o <= 1'b0;
      port_zero_in_refclk_oe_n_o <= 1'b1;
      port_zero_in_drive_16ma_o <= `PZI_DRIVE_12MA;
      port_zero_in_input_en_o <= 1'b0;
      port_zero_in_pulldown_en_o <= 1'b0;
    end else begin
      port_zero_in_refclk_o <= mode_phy ? gen_clk : 1'b0;
      port_zero_in_refclk_oe_n_o <= ~(mode_phy & ~virtual_phy_isolate_i);
      port_zero_in_drive_16ma_o <= (mode_phy & turbo_200_i) ? clk_strength_i : `PZI_DRIVE_12MA;
      port_zero_in_input_en_o <= ~iso_pins;
      port_zero_in_pulldown_en_o <= ~iso_pins;
    end
  end

////////////////////////////////////////////////////////////////////////
  // Edge of the active reference: PHY clock in MAC mode, own clock otherwise
  reg refclk_prev;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      refclk_prev <= 1'b0;
    end else begin
      refclk_prev <= s_refclk;
    end
  end
  wire ext_rise = mode_mac & s_refclk & ~refclk_prev;
  wire sample = ext_rise | (~mode_mac & gen_rise);

  wire use_valid = s_valid & ~iso_pins;
  wire use_error = s_error & ~iso_pins & ~mode_rmii;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      rx_strobe_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_bits_o <= 4'h0;
      rx_width_rmii_o <= 1'b0;
      rx_error_mark_o <= 1'b0;
      rx_abort_o <= 1'b0;
    end else begin
      rx_strobe_o <= sample;
      rx_error_mark_o <= 1'b0;
      rx_abort_o <= 1'b0;
      rx_width_rmii_o <= mode_rmii;
      if (sample) begin
        rx_valid_o <= use_valid;
        if (use_valid & mode_rmii) begin
          rx_bits_o <= {2'h0, s_bits[`PZI_RMII_BITS-1:0]};
        end else if (use_valid) begin
          rx_bits_o <= s_bits;
        end else begin
          rx_bits_o <= 4'h0;
        end
        rx_error_mark_o <= use_valid & use_error & mode_mac;
        rx_abort_o <= use_valid & use_error & mode_phy;
      end
    end
  end
endmodule // pzi_port_zero_in
`default_nettype wire

// ===== bench/pzi_chk.sv
/* Assertions on the block's ports.
   Bound from the bench top. */
`timescale 1ns/1ns
`default_nettype none
module pzi_chk (
  // Clock, reset, config
  input wire logic clk_sys_i, reset_i, virtual_phy_isolate_i, clk_strength_i, turbo_200_i,
  input wire logic [1:0] port_mode_i,
  // Watched outputs
  input wire logic port_zero_in_refclk_o, port_zero_in_refclk_oe_n_o, port_zero_in_drive_16ma_o,
  input wire logic port_zero_in_input_en_o, port_zero_in_pulldown_en_o, rx_strobe_o, rx_valid_o,
  input wire logic rx_width_rmii_o, rx_error_mark_o, rx_abort_o,
  input wire logic [3:0] rx_bits_o
);
  wire logic [1:0] m = port_mode_i;
  wire logic s = rx_strobe_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Pin controls lag config by one edge
  sequence s_beat; s && rx_valid_o ##1 !s; endsequence
  property p_oe; !$past(reset_i) |-> port_zero_in_refclk_oe_n_o ==
    !($past(m) == 2'h1 && !$past(virtual_phy_isolate_i)); endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_drv; !$past(reset_i) |-> port_zero_in_drive_16ma_o ==
    ($past(m) == 2'h1 && $past(turbo_200_i) && $past(clk_strength_i)); endproperty
  a_drv: assert property (p_drv) else $error("drive");
  property p_in; !$past(reset_i) |-> port_zero_in_pulldown_en_o == port_zero_in_input_en_o &&
    port_zero_in_input_en_o == !(($past(m) == 2'h1 || $past(m) == 2'h2) && $past(virtual_phy_isolate_i));
  endproperty
  a_in: assert property (p_in) else $error("input en");
  property p_clk; !$past(reset_i) && $past(m) != 2'h1 |-> !port_zero_in_refclk_o; endproperty
  a_clk: assert property (p_clk) else $error("refclk");
  property p_err; rx_error_mark_o |-> m == 2'h0 ##0 s_beat; endproperty
  a_err: assert property (p_err) else $error("mark");
  property p_abt; rx_abort_o |-> m == 2'h1 ##0 s_beat; endproperty
  a_abt: assert property (p_abt) else $error("abort");
  property p_hold; !s |-> $stable(rx_bits_o) && $stable(rx_valid_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_rmii; rx_width_rmii_o |-> rx_bits_o[3:2] == 2'h0; endproperty
  a_rmii: assert property (p_rmii) else $error("dibit");
endmodule // pzi_chk
`default_nettype wire

// ===== bench/pzi_far_end.sv
/* Far-side PHY or MAC driving the input pins.
   Assumes mode stays put while traffic runs. */
`timescale 1ns/1ns
`default_nettype none
module pzi_far_end (
  input wire logic [1:0] mode_i,
  input wire logic dev_clk_i,
  input wire logic [5:0] want_i,
  output logic [5:0] pins_o,
  output logic [5:0] snap_o,
  output logic clk_o
);
  initial clk_o = 1'b0;
  always #40 clk_o = (mode_i == 2'h0) ? !clk_o : 1'b0;
  // Device clock in PHY modes; strobe stands in for the shared reference
  wire logic ck = (mode_i == 2'h0) ? clk_o : dev_clk_i;
  // Launch on fall so pins sit still around the sampling rise
  always @(negedge ck) pins_o <= want_i;
  always @(posedge ck) snap_o <= pins_o;
endmodule // pzi_far_end
`default_nettype wire

// ===== bench/pzi_port_zero_in_tb.sv
/* Random bench for the block.
   Assumes checker and far end compiled first. */
`timescale 1ns/1ns
`default_nettype none
module pzi_port_zero_in_tb;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, iso = 1'b0, str = 1'b0, turbo = 1'b0, on = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [5:0] want = 6'h0;
  wire logic [5:0] pins, snap;
  wire logic rin, rout, s, v, w, em, ab;
  wire logic [3:0] b;
  integer seed = 32'h6f189fa3, bad_count = 0, num_checks = 0, k;
  always #5 clk_sys_i = !clk_sys_i;
  pzi_port_zero_in pzi_port_zero_in_inst (.clk_sys_i, .reset_i, .port_mode_i(mode),
    .virtual_phy_isolate_i(iso), .clk_strength_i(str), .turbo_200_i(turbo),
    .port_zero_in_valid_i(pins[5]), .port_zero_in_error_i(pins[4]), .port_zero_in_bits_i(pins[3:0]),
    .port_zero_in_refclk_i(rin), .port_zero_in_refclk_o(rout), .port_zero_in_refclk_oe_n_o(),
    .port_zero_in_drive_16ma_o(), .port_zero_in_input_en_o(), .port_zero_in_pulldown_en_o(),
    .rx_strobe_o(s), .rx_valid_o(v), .rx_bits_o(b), .rx_width_rmii_o(w), .rx_error_mark_o(em),
    .rx_abort_o(ab));
  pzi_far_end pzi_far_end_inst (.mode_i(mode), .dev_clk_i(mode == 2'h1 ? rout : s), .want_i(want),
    .pins_o(pins), .snap_o(snap), .clk_o(rin));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function logic [7:0] beat(input logic [5:0] p);
    logic dv;
    dv = p[5] && !(iso && mode != 2'h0);
    beat = {mode == 2'h2, dv, dv && p[4] && mode == 2'h0, dv && p[4] && mode == 2'h1,
      dv ? (mode == 2'h2 ? {2'h0, p[1:0]} : p[3:0]) : 4'h0};
  endfunction
  always @(negedge clk_sys_i) if (on && s === 1'b1) check({w, v, em, ab, v ? b : 4'h0}, beat(snap));
  ////////////////////////////////////////
  // Quiet pins across a config change so no beat straddles it
  task run(input logic [1:0] md, input logic is);
    on = 1'b0;
    want = 6'h0;
    repeat (40) @(negedge clk_sys_i);
    mode = md;
    iso = is;
    turbo = $random(seed);
    str = $random(seed);
    repeat (40) @(negedge clk_sys_i);
    on = 1'b1;
    repeat (400) begin
      @(negedge clk_sys_i);
      want = $random(seed);
    end
  endtask
  task results;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_i);
    reset_i = 1'b0;
    for (k = 0; k < 9; k++) run(2'(k % 3), k > 2 && k < 6);
    results;
  end
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule // pzi_port_zero_in_tb
bind pzi_port_zero_in pzi_chk pzi_chk_inst (.*);
`default_nettype wire
